// >>> include/crt_pkg.sv
// Behaviour
// - Index write loads register number bits 0-4
// - Select low: write index, read status
// - Data lines driven only while selected
// - Phase-2 clock times transfers, direction by input
// - Row starts line zero (line one in odd video-interlace fields), address increments per tick
// - Window drops at displayed count, counting continues
// - Line sync rises at programmed position
// - Line sync lasts low-nibble characters, zero invalid
// - Line ends after total plus one characters
// - Next row: next start address, line zero (line one in odd video-interlace fields)
// - Non-display rows scanned with window low
// - Field sync at programmed row, high-nibble lines
// - High nibble zero gives sixteen lines
// - Adjust lines added after last row
// - Field starts at start address, bits 6-7 zero
// - Addresses wrap to zero past display end
// - Caret first line and four caret modes
// - Caret at matching address within line span
// - Pen edge captures address, high bits zero
// - Pen capture lags one character time
// - Interlace alternates fields, odd sync half-line late
// - Row-line address is four bits
package crt_pkg;
  localparam int ADDR_W = 14;
  localparam logic [4:0] REG_LINE_TOTAL = 5'h00;
  localparam logic [4:0] REG_CHARS_DISP = 5'h01;
  localparam logic [4:0] REG_HSYNC_POS = 5'h02;
  localparam logic [4:0] REG_SYNC_WIDTHS = 5'h03;
  localparam logic [4:0] REG_ROW_TOTAL = 5'h04;
  localparam logic [4:0] REG_ROW_ADJUST = 5'h05;
  localparam logic [4:0] REG_ROWS_DISP = 5'h06;
  localparam logic [4:0] REG_VSYNC_ROW = 5'h07;
  localparam logic [4:0] REG_SCAN_MODE = 5'h08;
  localparam logic [4:0] REG_LINES_ROW = 5'h09;
  localparam logic [4:0] REG_CARET_FIRST = 5'h0a;
  localparam logic [4:0] REG_CARET_LAST = 5'h0b;
  localparam logic [4:0] REG_START_HI = 5'h0c;
  localparam logic [4:0] REG_START_LO = 5'h0d;
  localparam logic [4:0] REG_CARET_HI = 5'h0e;
  localparam logic [4:0] REG_CARET_LO = 5'h0f;
  localparam logic [4:0] REG_PEN_HI = 5'h10;
  localparam logic [4:0] REG_PEN_LO = 5'h11;
  localparam int STAT_PEN_BIT = 6;
  localparam int STAT_VBLANK_BIT = 5;
  localparam logic [4:0] VS_ZERO_LINES = 5'h10;
  localparam logic [1:0] CARET_STEADY = 2'h0;
  localparam logic [1:0] CARET_NONE = 2'h1;
  localparam logic [1:0] CARET_BLINK16 = 2'h2;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;
  localparam logic [1:0] MODE_IL_SYNC = 2'h1;
  localparam logic [1:0] MODE_IL_VIDEO = 2'h3;
  localparam int BUF_DEPTH = 2;
  typedef enum logic {CRT_ROWS, CRT_ADJUST} crt_vphase_t;
endpackage

// >>> rtl/crt_raster_timing_controller.sv
`timescale 1ns/100ps
module crt_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Receiver takes
  output logic [WIDTH-1:0] out_data // Word out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  if (DEPTH < 2) $error("buffer needs two entries");

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module crt_raster_timing_controller
  import crt_pkg::*;
#(
  parameter int CA_W = 11
) (
  input wire logic REF_CLK, // 25 MHz clock
  input wire logic RST_N, // Sync reset, active low
  input wire logic PHASE2, // Host phase-2 clock, sampled
  input wire logic SELECT_N, // Controller select, active low
  input wire logic REG_SELECT, // Low: index/status, high: data reg
  input wire logic READ_NOT_WRITE, // High reads
  input wire logic [7:0] DATA_IN, // Host data in
  output logic [7:0] DATA_OUT, // Host data out
  output logic DATA_OE, // Drive data lines
  input wire logic GLYPH_TICK, // Character clock, sampled
  input wire logic PEN_STROBE, // Light pen input
  output logic VID_VALID, // Raster word available
  input wire logic VID_READY, // Receiver takes raster word
  output logic [CA_W-1:0] CHAR_ADDRESS, // Character memory address
  output logic [3:0] ROW_LINE_ADDRESS, // Scan line within row
  output logic LINE_SYNC, // Horizontal sync
  output logic FIELD_SYNC, // Vertical sync
  output logic DISPLAY_WINDOW, // Displayed character
  output logic CARET_FLAG // Caret position
);
  import crt_pkg::*;
  localparam int WORD_W = CA_W + 8;

  if (CA_W < 1 || CA_W > ADDR_W) $error("CA_W out of range");

  logic [4:0] index_reg;
  logic [7:0] line_total_reg, chars_disp_reg, hsync_pos_reg, sync_widths_reg;
  logic [6:0] row_total_reg, rows_disp_reg, vsync_row_reg, caret_first_reg;
  logic [4:0] row_adjust_reg, lines_row_reg, caret_last_reg;
  logic [7:0] scan_mode_reg;
  logic [ADDR_W-1:0] start_reg, caret_addr_reg, pen_addr_reg;
  logic phase2_q, tick_q, pen_q, pen_pend_reg, pen_flag_reg;
  logic [7:0] h_cnt_reg;
  logic [4:0] line_cnt_reg, adj_cnt_reg, vs_cnt_reg, blink_reg;
  logic [6:0] row_cnt_reg;
  logic [3:0] hs_cnt_reg;
  logic [ADDR_W-1:0] row_start_reg;
  logic field_odd_reg;
  crt_vphase_t vphase_reg;
  logic [7:0] rd_next;
  logic bus_fall, wr_take, rd_take, adv, buf_ready;
  logic h_end, line_last, row_end, field_end, interlace, il_video;
  logic [ADDR_W-1:0] disp_size, cur_addr, next_row_start;
  logic [4:0] line_first, vs_width;
  logic [7:0] vs_upd_pos;
  logic hs_now, vs_start, vs_now, win_now, caret_now, blink_on;
  logic [WORD_W-1:0] word_in, word_out;

  function automatic logic [ADDR_W-1:0] wrap_add(input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] lim);
    logic [ADDR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (lim != '0 && s >= {1'b0, lim})
      s = s - {1'b0, lim};
    return s[ADDR_W-1:0];
  endfunction

  // Host transfers close on the falling edge of the phase-2 clock
  assign bus_fall = phase2_q & ~PHASE2;
  assign wr_take = bus_fall & ~SELECT_N & ~READ_NOT_WRITE;
  assign rd_take = bus_fall & ~SELECT_N & READ_NOT_WRITE;
  assign DATA_OE = ~SELECT_N & READ_NOT_WRITE;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      phase2_q <= 1'b0;
      tick_q <= 1'b0;
      pen_q <= 1'b0;
    end
    else
    begin
      phase2_q <= PHASE2;
      tick_q <= GLYPH_TICK;
      pen_q <= PEN_STROBE;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      index_reg <= '0;
      line_total_reg <= '0;
      chars_disp_reg <= '0;
      hsync_pos_reg <= '0;
      sync_widths_reg <= '0;
      row_total_reg <= '0;
      row_adjust_reg <= '0;
      rows_disp_reg <= '0;
      vsync_row_reg <= '0;
      scan_mode_reg <= '0;
      lines_row_reg <= '0;
      caret_first_reg <= '0;
      caret_last_reg <= '0;
      start_reg <= '0;
      caret_addr_reg <= '0;
    end
    else if (wr_take)
    begin
      if (!REG_SELECT)
        index_reg <= DATA_IN[4:0];
      else
      begin
        unique case (index_reg)
          REG_LINE_TOTAL: line_total_reg <= DATA_IN;
          REG_CHARS_DISP: chars_disp_reg <= DATA_IN;
          REG_HSYNC_POS: hsync_pos_reg <= DATA_IN;
          REG_SYNC_WIDTHS: sync_widths_reg <= DATA_IN;
          REG_ROW_TOTAL: row_total_reg <= DATA_IN[6:0];
          REG_ROW_ADJUST: row_adjust_reg <= DATA_IN[4:0];
          REG_ROWS_DISP: rows_disp_reg <= DATA_IN[6:0];
          REG_VSYNC_ROW: vsync_row_reg <= DATA_IN[6:0];
          REG_SCAN_MODE: scan_mode_reg <= DATA_IN;
          REG_LINES_ROW: lines_row_reg <= DATA_IN[4:0];
          REG_CARET_FIRST: caret_first_reg <= DATA_IN[6:0];
          REG_CARET_LAST: caret_last_reg <= DATA_IN[4:0];
          REG_START_HI: start_reg[13:8] <= DATA_IN[5:0];
          REG_START_LO: start_reg[7:0] <= DATA_IN;
          REG_CARET_HI: caret_addr_reg[13:8] <= DATA_IN[5:0];
          REG_CARET_LO: caret_addr_reg[7:0] <= DATA_IN;
          default: ;
        endcase
      end
    end
  end

  always_comb
  begin
    rd_next = 8'h00;
    if (!REG_SELECT)
    begin
      rd_next[STAT_PEN_BIT] = pen_flag_reg;
      rd_next[STAT_VBLANK_BIT] = (vphase_reg == CRT_ADJUST) || (row_cnt_reg >= rows_disp_reg);
    end
    else
    begin
      unique case (index_reg)
        REG_START_HI: rd_next = {2'h0, start_reg[13:8]};
        REG_START_LO: rd_next = start_reg[7:0];
        REG_CARET_HI: rd_next = {2'h0, caret_addr_reg[13:8]};
        REG_CARET_LO: rd_next = caret_addr_reg[7:0];
        REG_PEN_HI: rd_next = {2'h0, pen_addr_reg[13:8]};
        REG_PEN_LO: rd_next = pen_addr_reg[7:0];
        default: rd_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      DATA_OUT <= 8'h00;
    else
      DATA_OUT <= rd_next;
  end

  // Raster steps only when the buffer has room, so no word is dropped
  assign adv = GLYPH_TICK & ~tick_q & buf_ready;
  assign interlace = scan_mode_reg[0];
  assign il_video = (scan_mode_reg[1:0] == MODE_IL_VIDEO);
  assign line_first = il_video ? {4'h0, field_odd_reg} : 5'h00;
  assign h_end = (h_cnt_reg == line_total_reg);
  // Video interlace walks every other line, so compare without bit 0
  assign line_last = il_video ? ((line_cnt_reg | 5'h01) == (lines_row_reg | 5'h01))
                              : (line_cnt_reg == lines_row_reg);
  assign row_end = (vphase_reg == CRT_ROWS) && line_last;
  assign field_end = h_end && ((row_end && row_cnt_reg == row_total_reg && row_adjust_reg == '0)
    || (vphase_reg == CRT_ADJUST && adj_cnt_reg + 5'h01 == row_adjust_reg));
  assign disp_size = ADDR_W'({6'h00, chars_disp_reg} * {7'h00, rows_disp_reg});
  assign cur_addr = wrap_add(row_start_reg, {6'h00, h_cnt_reg}, disp_size);
  assign next_row_start = wrap_add(row_start_reg, {6'h00, chars_disp_reg}, disp_size);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      h_cnt_reg <= '0;
    else if (adv)
      h_cnt_reg <= h_end ? 8'h00 : h_cnt_reg + 8'h01;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      line_cnt_reg <= '0;
      row_cnt_reg <= '0;
      adj_cnt_reg <= '0;
      vphase_reg <= CRT_ROWS;
      row_start_reg <= '0;
      field_odd_reg <= 1'b0;
      blink_reg <= '0;
    end
    else if (adv && h_end)
    begin
      if (field_end)
      begin
        vphase_reg <= CRT_ROWS;
        row_cnt_reg <= '0;
        adj_cnt_reg <= '0;
        row_start_reg <= start_reg;
        field_odd_reg <= interlace ? ~field_odd_reg : 1'b0;
        line_cnt_reg <= (il_video && !field_odd_reg) ? 5'h01 : 5'h00;
        blink_reg <= blink_reg + 5'h01;
      end
      else if (vphase_reg == CRT_ADJUST)
        adj_cnt_reg <= adj_cnt_reg + 5'h01;
      else if (row_end && row_cnt_reg == row_total_reg)
        vphase_reg <= CRT_ADJUST;
      else if (row_end)
      begin
        row_cnt_reg <= row_cnt_reg + 7'h01;
        row_start_reg <= next_row_start;
        line_cnt_reg <= line_first;
      end
      else
        line_cnt_reg <= line_cnt_reg + (il_video ? 5'h02 : 5'h01);
    end
  end

  // Zero width is invalid; treated as no pulse rather than a stuck sync
  assign hs_now = (adv && h_cnt_reg == hsync_pos_reg && sync_widths_reg[3:0] != '0)
    || hs_cnt_reg != '0;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      hs_cnt_reg <= '0;
    else if (adv)
    begin
      if (h_cnt_reg == hsync_pos_reg && sync_widths_reg[3:0] != '0)
        hs_cnt_reg <= sync_widths_reg[3:0] - 4'h1;
      else if (hs_cnt_reg != '0)
        hs_cnt_reg <= hs_cnt_reg - 4'h1;
    end
  end

  // Odd interlaced fields move the sync edges to mid-line
  assign vs_upd_pos = (interlace && field_odd_reg)
    ? {1'b0, line_total_reg[7:1]} + {7'h00, line_total_reg[0]} : 8'h00;
  assign vs_width = (sync_widths_reg[7:4] == '0) ? VS_ZERO_LINES
                                                 : {1'b0, sync_widths_reg[7:4]};
  assign vs_start = vphase_reg == CRT_ROWS && row_cnt_reg == vsync_row_reg
    && line_cnt_reg == line_first;
  // Shown from the loading character up to the one before the count expires
  assign vs_now = (h_cnt_reg == vs_upd_pos) ? (vs_start || vs_cnt_reg > 5'h01)
                                            : (vs_cnt_reg != '0);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      vs_cnt_reg <= '0;
    else if (adv && h_cnt_reg == vs_upd_pos)
    begin
      if (vs_start)
        vs_cnt_reg <= vs_width;
      else if (vs_cnt_reg != '0)
        vs_cnt_reg <= vs_cnt_reg - 5'h01;
    end
  end

  assign win_now = vphase_reg == CRT_ROWS && row_cnt_reg < rows_disp_reg
    && h_cnt_reg < chars_disp_reg;
  assign blink_on = (caret_first_reg[6:5] == CARET_STEADY)
    || (caret_first_reg[6:5] == CARET_BLINK16 && blink_reg[BLINK16_BIT])
    || (caret_first_reg[6:5] == 2'h3 && blink_reg[BLINK32_BIT]);
  assign caret_now = blink_on && cur_addr == caret_addr_reg
    && line_cnt_reg >= caret_first_reg[4:0] && line_cnt_reg <= caret_last_reg;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      pen_pend_reg <= 1'b0;
      pen_addr_reg <= '0;
    end
    else
    begin
      if (PEN_STROBE && !pen_q)
        pen_pend_reg <= 1'b1;
      else if (adv)
        pen_pend_reg <= 1'b0;
      if (adv && pen_pend_reg)
        pen_addr_reg <= cur_addr;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      pen_flag_reg <= 1'b0;
    else if (adv && pen_pend_reg)
      pen_flag_reg <= 1'b1;
    else if (rd_take && REG_SELECT && index_reg == REG_PEN_LO)
      pen_flag_reg <= 1'b0;
  end

  assign word_in = {caret_now, win_now, vs_now, hs_now,
    line_cnt_reg[3:0], cur_addr[CA_W-1:0]};

  crt_skid_buffer #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_valid(adv),
    .in_ready(buf_ready),
    .in_data(word_in),
    .out_valid(VID_VALID),
    .out_ready(VID_READY),
    .out_data(word_out)
  );

  assign {CARET_FLAG, DISPLAY_WINDOW, FIELD_SYNC, LINE_SYNC, ROW_LINE_ADDRESS, CHAR_ADDRESS} =
    VID_VALID ? word_out : '0;

  a_index_load: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_take && !REG_SELECT |=> index_reg == $past(DATA_IN[4:0]))
    else $error("index not loaded");
  a_status_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !REG_SELECT && !pen_flag_reg |=> !DATA_OUT[STAT_PEN_BIT])
    else $error("status read wrong");
  a_bus_float: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    SELECT_N |-> !DATA_OE)
    else $error("data driven while deselected");
  a_window_off: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    h_cnt_reg >= chars_disp_reg |-> !win_now)
    else $error("window high past displayed count");
  a_hsync_rise: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    adv && h_cnt_reg == hsync_pos_reg && sync_widths_reg[3:0] != '0 |-> hs_now)
    else $error("line sync missed");
  a_line_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    adv && h_end |=> h_cnt_reg == '0)
    else $error("line did not wrap");
  a_vsync_len16: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    adv && h_cnt_reg == vs_upd_pos && vs_start && sync_widths_reg[7:4] == '0
    |=> vs_cnt_reg == VS_ZERO_LINES)
    else $error("zero width not sixteen lines");
  a_pen_capture: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    adv && pen_pend_reg |=> pen_addr_reg == $past(cur_addr) && pen_flag_reg)
    else $error("pen address not captured");
  a_caret_none: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    caret_first_reg[6:5] == CARET_NONE |-> !caret_now)
    else $error("caret shown in no-caret mode");
endmodule

// >>> verif/crt_host_model.sv
`timescale 1ns/100ps
module crt_host_model (
  input logic clk, // Bus clock
  input logic [7:0] data_out, // Controller read data
  input logic data_oe, // Controller drives data
  output logic phase2, // Phase-2 clock
  output logic select_n, // Chip select, active low
  output logic reg_select, // Index/status or data register
  output logic read_not_write, // High reads
  output logic [7:0] data_in // Write data
);
  initial
  begin
    phase2 = 1'b0;
    select_n = 1'b1;
    reg_select = 1'b0;
    read_not_write = 1'b1;
    data_in = 8'h00;
  end
  // Pins held from setup until one clock after the edge that closes the phase-2 pulse
  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] wd,
    output logic [7:0] rdv, output logic oe);
    @(negedge clk);
    select_n = 1'b0;
    read_not_write = rnw;
    reg_select = rs;
    data_in = wd;
    phase2 = 1'b1;
    @(negedge clk);
    phase2 = 1'b0;
    @(posedge clk);
    rdv = data_out;
    oe = data_oe;
    @(negedge clk);
    select_n = 1'b1;
    // Released lines do not keep the last value
    data_in = ~wd;
  endtask
  task automatic set_reg(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] d;
    logic o;
    xfer(1'b0, 1'b0, {3'h0, idx}, d, o);
    xfer(1'b1, 1'b0, v, d, o);
  endtask
  task automatic get_reg(input logic [4:0] idx, output logic [7:0] v, output logic oe);
    logic [7:0] d;
    logic o;
    xfer(1'b0, 1'b0, {3'h0, idx}, d, o);
    xfer(1'b1, 1'b1, 8'h00, v, oe);
  endtask
endmodule

// >>> verif/crt_raster_timing_controller_tb_top.sv
`timescale 1ns/100ps
module crt_raster_timing_controller_tb_top;
  import crt_pkg::*;
  localparam int LT = 7, CD = 4, HP = 5, HW = 2, RT = 3, ADJ = 1, RD = 2, VR = 2, VW = 3;
  localparam int LINES = 2, CHARS = LT + 1, PER_FIELD = CHARS * ((RT + 1) * LINES + ADJ);
  localparam logic [4:0] IDX [16] = '{REG_LINE_TOTAL, REG_CHARS_DISP, REG_HSYNC_POS,
    REG_SYNC_WIDTHS, REG_ROW_TOTAL, REG_ROW_ADJUST, REG_ROWS_DISP, REG_VSYNC_ROW,
    REG_SCAN_MODE, REG_LINES_ROW, REG_CARET_FIRST, REG_CARET_LAST, REG_START_HI,
    REG_START_LO, REG_CARET_HI, REG_CARET_LO};
  localparam logic [7:0] VAL [16] = '{8'(LT), 8'(CD), 8'(HP), 8'(VW * 16 + HW), 8'(RT),
    8'(ADJ), 8'(RD), 8'(VR), 8'h00, 8'(LINES - 1), 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h05};
  logic ref_clk, rst_n, phase2, select_n, reg_select, read_not_write, data_oe;
  logic [7:0] data_in, data_out, v;
  logic glyph_tick, pen_strobe, vid_valid, vid_ready, oe;
  logic [10:0] char_address;
  logic [3:0] row_line_address;
  logic line_sync, field_sync, display_window, caret_flag;
  int num_errors = 0, tests_run = 0, rcv = 0, cycles = 0;
  crt_raster_timing_controller #(.CA_W(11)) i_crt_raster_timing_controller (
    .REF_CLK(ref_clk), .RST_N(rst_n), .PHASE2(phase2), .SELECT_N(select_n),
    .REG_SELECT(reg_select), .READ_NOT_WRITE(read_not_write), .DATA_IN(data_in),
    .DATA_OUT(data_out), .DATA_OE(data_oe), .GLYPH_TICK(glyph_tick),
    .PEN_STROBE(pen_strobe), .VID_VALID(vid_valid), .VID_READY(vid_ready),
    .CHAR_ADDRESS(char_address), .ROW_LINE_ADDRESS(row_line_address),
    .LINE_SYNC(line_sync), .FIELD_SYNC(field_sync), .DISPLAY_WINDOW(display_window),
    .CARET_FLAG(caret_flag));
  crt_host_model i_crt_host_model (.clk(ref_clk), .data_out(data_out), .data_oe(data_oe),
    .phase2(phase2), .select_n(select_n), .reg_select(reg_select),
    .read_not_write(read_not_write), .data_in(data_in));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out();
    end
  end
  // Expected word follows from the count of words taken, so dropped ticks must not advance
  task automatic check_word();
    int f, p, ln, h, r, l, st, q;
    logic de, fs;
    logic [10:0] ca;
    f = rcv / PER_FIELD;
    p = rcv % PER_FIELD;
    ln = p / CHARS;
    h = p % CHARS;
    r = ln / LINES;
    l = ln % LINES;
    st = (f == 0) ? 0 : 2;
    de = (ln < RD * LINES) && (h < CD);
    ca = 11'((st + r * CD + h) % (CD * RD));
    chk("window", 16'(de), 16'(display_window));
    chk("line_sync", 16'(h >= HP && h < HP + HW), 16'(line_sync));
    // The fourth field is odd under interlace sync: sync edges move half a line
    q = ln * CHARS + h - ((f == 3) ? CHARS / 2 : 0);
    fs = (q >= VR * LINES * CHARS) && (q < (VR * LINES + VW) * CHARS);
    chk("field_sync", 16'(fs), 16'(field_sync));
    if (de)
    begin
      chk("char_address", 16'(ca), 16'(char_address));
      chk("row_line", 16'(l), 16'(row_line_address));
      chk("caret", 16'(f == 0 && ca == 5 && l == 1), 16'(caret_flag));
    end
    rcv++;
  endtask
  always @(posedge ref_clk)
    if (rst_n === 1'b1 && vid_valid === 1'b1 && vid_ready === 1'b1)
      check_word();
  task automatic t_regs();
    i_crt_host_model.set_reg(REG_START_HI, 8'hff);
    i_crt_host_model.get_reg(REG_START_HI, v, oe);
    chk("start_hi", 16'h003f, {8'h00, v});
    chk("read_oe", 16'h0001, 16'(oe));
    @(negedge ref_clk);
    chk("idle_oe", 16'h0000, 16'(data_oe));
    i_crt_host_model.set_reg(REG_CARET_HI, 8'hc0);
    i_crt_host_model.get_reg(REG_CARET_HI, v, oe);
    chk("caret_hi", 16'h0000, {8'h00, v});
    i_crt_host_model.set_reg(REG_LINE_TOTAL, 8'h5a);
    i_crt_host_model.get_reg(REG_LINE_TOTAL, v, oe);
    chk("write_only", 16'h0000, {8'h00, v});
    i_crt_host_model.set_reg(REG_PEN_HI, 8'hff);
    i_crt_host_model.get_reg(REG_PEN_HI, v, oe);
    chk("pen_hi_ro", 16'h0000, {8'h00, v});
    i_crt_host_model.xfer(1'b0, 1'b1, 8'h00, v, oe);
    chk("status_idle", 16'h0000, 16'(v[STAT_PEN_BIT]));
  endtask
  task automatic t_program();
    for (int i = 0; i < 16; i++)
      i_crt_host_model.set_reg(IDX[i], VAL[i]);
  endtask
  // Stall the receiver mid-line, strobe the pen, move start and caret mode before field two
  task automatic t_field();
    bit moved;
    moved = 1'b0;
    for (int i = 0; i < 400 && rcv < 2 * PER_FIELD; i++)
    begin
      @(negedge ref_clk);
      vid_ready = !(i >= 20 && i < 25);
      pen_strobe = (i == 30);
      glyph_tick = 1'b1;
      repeat (2) @(negedge ref_clk);
      glyph_tick = 1'b0;
      @(negedge ref_clk);
      if (i == 24)
        chk("stall_valid", 16'h0001, 16'(vid_valid));
      if (rcv >= 64 && !moved)
      begin
        moved = 1'b1;
        i_crt_host_model.set_reg(REG_START_LO, 8'h02);
        i_crt_host_model.set_reg(REG_CARET_FIRST, 8'h21);
      end
    end
    chk("words", 16'(2 * PER_FIELD), 16'(rcv));
  endtask
  task automatic t_pen();
    i_crt_host_model.xfer(1'b0, 1'b1, 8'h00, v, oe);
    chk("status_pen", 16'h0001, 16'(v[STAT_PEN_BIT]));
    i_crt_host_model.get_reg(REG_PEN_HI, v, oe);
    chk("pen_hi", 16'h0000, {8'h00, v});
    i_crt_host_model.get_reg(REG_PEN_LO, v, oe);
    chk("pen_lo", 16'h0007, {8'h00, v});
    i_crt_host_model.xfer(1'b0, 1'b1, 8'h00, v, oe);
    chk("status_clear", 16'h0000, 16'(v[STAT_PEN_BIT]));
  endtask
  // Interlace sync from field three on: the following odd field shifts its sync
  task automatic t_interlace();
    i_crt_host_model.set_reg(REG_SCAN_MODE, {6'h00, MODE_IL_SYNC});
    for (int i = 0; i < 400 && rcv < 4 * PER_FIELD; i++)
    begin
      @(negedge ref_clk);
      glyph_tick = 1'b1;
      repeat (2) @(negedge ref_clk);
      glyph_tick = 1'b0;
      @(negedge ref_clk);
    end
    chk("il_words", 16'(4 * PER_FIELD), 16'(rcv));
  endtask
  initial
  begin
    rst_n = 1'b0;
    glyph_tick = 1'b0;
    pen_strobe = 1'b0;
    vid_ready = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    t_regs();
    t_program();
    t_field();
    t_pen();
    t_interlace();
    close_out();
  end
endmodule
